// >>> rtl/luexe_core.sv
// execution unit: logical, upper-immediate adds, pc-relative adds, delay-slot branches
//
// Overview of operation
// - aligned pc upper add clears the low 16 bits of the sum
// - register and: destination gets first source and second source
// - mask with constant: zero-extended immediate anded, written to second field
// - upper immediate add: 32-bit sum sign-extended to 64 bits
// - dword upper add writes the full 64-bit sum
// - high slice add: immediate shifted 32, added, same register overwritten
// - top slice add: immediate shifted 48, added, same register overwritten
// - dword upper add with source zero traps as reserved
// - 64-bit adds trap when 64-bit operations are disabled
// - legacy mode jump opcode decodes as dword upper add
// - load-upper idiom runs as upper add with zero source
// - pc upper add: shifted immediate plus own address
// - pc upper add result sign-extended from bit 31
// - unconditional branch is equal-compare of zero against zero
// - target is offset shifted 2 plus delay-slot address
// - call relative link writes register 31 with branch address plus 8
// - control transfer in a delay slot raises reserved trap
`include "luexe_regs.svh"
module luexe_core (
  input wire logic clk,
  input wire logic rstn,
  input wire logic issue,
  input wire logic [31:0] instr,
  input wire logic [63:0] pc,
  input wire logic [63:0] src_a,
  input wire logic [63:0] src_b,
  input wire logic en64,
  output logic wr_en_q,
  output logic [4:0] wr_reg_q,
  output logic [63:0] wr_data_q,
  output logic redirect_q,
  output logic [63:0] target_q,
  output logic trap_q
);
  luexe_dec_if dif ();
  logic in_slot_q;
  logic pend_q;
  logic [63:0] pend_target_q;
  logic [63:0] sum;
  logic [63:0] res;
  logic slot_cti;

  // forms that redirect once their slot word has gone through
  function automatic logic is_taken(input luexe_pkg::luexe_kind_t k);
    return (k == luexe_pkg::LUEXE_BRANCH) || (k == luexe_pkg::LUEXE_LINK);
  endfunction

  luexe_decode u_dec (
    .instr(instr),
    .en64(en64),
    .d(dif)
  );

  // one adder serves register and pc based forms
  assign sum = ((dif.kind == luexe_pkg::LUEXE_PCADD) ? pc : src_a) + dif.addend;
  assign slot_cti = in_slot_q && dif.cti;

  // result shaping per operation
  always_comb begin
    res = sum;
    unique case (dif.kind)
      luexe_pkg::LUEXE_AND: res = src_a & src_b;
      luexe_pkg::LUEXE_MASK: res = src_a & dif.addend;
      luexe_pkg::LUEXE_LINK: res = pc + `LUEXE_LINK_STEP;
      default: begin
        if (dif.is32) begin
          res = {{32{sum[31]}}, sum[31:16], (dif.align ? 16'h0000 : sum[15:0])};
        end
      end
    endcase
  end

  // register write port; trap suppresses the write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_en_q <= 1'b0;
      wr_reg_q <= 5'h00;
      wr_data_q <= 64'h0;
    end else begin
      wr_en_q <= issue && !slot_cti && (dif.kind inside {luexe_pkg::LUEXE_AND, luexe_pkg::LUEXE_MASK,
        luexe_pkg::LUEXE_ADD, luexe_pkg::LUEXE_PCADD, luexe_pkg::LUEXE_LINK});
      wr_reg_q <= dif.dest;
      wr_data_q <= res;
    end
  end

  // reserved trap request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trap_q <= 1'b0;
    end else begin
      trap_q <= issue && (dif.kind == luexe_pkg::LUEXE_TRAP || slot_cti);
    end
  end

  // slot tracking: the next issued word is the slot, whatever the gap;
  // other equal-compare branches handled elsewhere still open a slot, a trapped cti opens none
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_slot_q <= 1'b0;
    end else if (issue) begin
      in_slot_q <= !in_slot_q && dif.cti;
    end
  end

  // pending redirect, only for the forms this unit resolves
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_q <= 1'b0;
    end else if (issue) begin
      pend_q <= !in_slot_q && is_taken(dif.kind);
    end
  end

  // target is relative to the slot address, i.e. branch address plus four
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_target_q <= 64'h0;
    end else if (issue && !in_slot_q && is_taken(dif.kind)) begin
      pend_target_q <= pc + `LUEXE_SLOT_STEP + dif.addend;
    end
  end

  // redirect pulses one cycle after the slot word is taken
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      redirect_q <= 1'b0;
    end else begin
      redirect_q <= issue && in_slot_q && pend_q;
    end
  end

  // target only moves with a redirect, so the pipeline may read it late
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      target_q <= 64'h0;
    end else if (issue && in_slot_q && pend_q) begin
      target_q <= pend_target_q;
    end
  end
endmodule

// >>> rtl/luexe_dec_if.sv
// decoded operation handed from the decoder to the execute stage
interface luexe_dec_if;
  luexe_pkg::luexe_kind_t kind;
  logic [63:0] addend;
  logic [4:0] dest;
  logic is32;
  logic align;
  logic cti;
  modport dec (output kind, output addend, output dest, output is32, output align, output cti);
  modport exe (input kind, input addend, input dest, input is32, input align, input cti);
endinterface

// >>> rtl/luexe_decode.sv
// combinational decoder for the execution unit
`include "luexe_regs.svh"
module luexe_decode (
  input wire logic [31:0] instr,
  input wire logic en64,
  luexe_dec_if.dec d
);
  logic [5:0] op;
  logic [4:0] fs;
  logic [4:0] ft;
  logic [15:0] imm;
  assign op = instr[31:26];
  assign fs = instr[25:21];
  assign ft = instr[20:16];
  assign imm = instr[15:0];

  // classify operation and form the shifted, sign-extended addend; the mask constant is zero-extended and unshifted
  always_comb begin
    d.kind = luexe_pkg::LUEXE_NONE;
    d.addend = 64'h0;
    d.dest = 5'h00;
    d.is32 = 1'b0;
    d.align = 1'b0;
    d.cti = 1'b0;
    unique case (op)
      `LUEXE_OP_SPECIAL: begin
        if (instr[10:0] == {5'h00, `LUEXE_FN_AND}) begin
          d.kind = luexe_pkg::LUEXE_AND;
          d.dest = instr[15:11];
        end
      end
      `LUEXE_OP_MASK_CONST: begin
        d.kind = luexe_pkg::LUEXE_MASK;
        d.addend = {48'h0, imm};
        d.dest = ft;
      end
      `LUEXE_OP_UPPER_ADD: begin
        // load-upper idiom is just this with source zero
        d.kind = luexe_pkg::LUEXE_ADD;
        d.addend = {{32{imm[15]}}, imm, 16'h0000};
        d.dest = ft;
        d.is32 = 1'b1;
      end
      `LUEXE_OP_DWORD_UPPER: begin
        // this opcode no longer means the legacy mode jump
        d.kind = (fs == 5'h00 || !en64) ? luexe_pkg::LUEXE_TRAP : luexe_pkg::LUEXE_ADD;
        d.addend = {{32{imm[15]}}, imm, 16'h0000};
        d.dest = ft;
      end
      `LUEXE_OP_REGIMM: begin
        d.dest = fs;
        if (ft == `LUEXE_RT_HIGH_SLICE) begin
          d.kind = en64 ? luexe_pkg::LUEXE_ADD : luexe_pkg::LUEXE_TRAP;
          d.addend = {{16{imm[15]}}, imm, 32'h0};
        end else if (ft == `LUEXE_RT_TOP_SLICE) begin
          d.kind = en64 ? luexe_pkg::LUEXE_ADD : luexe_pkg::LUEXE_TRAP;
          d.addend = {imm, 48'h0};
        end else if (ft == `LUEXE_RT_LINK_BRANCH && fs == 5'h00) begin
          d.kind = luexe_pkg::LUEXE_LINK;
          d.dest = `LUEXE_LINK_REG;
          d.addend = {{46{imm[15]}}, imm, 2'b00};
          d.cti = 1'b1;
        end
      end
      `LUEXE_OP_EQ_BRANCH: begin
        if (fs == 5'h00 && ft == 5'h00) begin
          d.kind = luexe_pkg::LUEXE_BRANCH;
          d.addend = {{46{imm[15]}}, imm, 2'b00};
        end
        d.cti = 1'b1;
      end
      `LUEXE_OP_PCREL: begin
        if (ft == `LUEXE_RT_PC_UPPER || ft == `LUEXE_RT_PC_UPPER_AL) begin
          d.kind = luexe_pkg::LUEXE_PCADD;
          d.addend = {{32{imm[15]}}, imm, 16'h0000};
          d.dest = fs;
          d.is32 = 1'b1;
          d.align = (ft == `LUEXE_RT_PC_UPPER_AL);
        end
      end
      default: begin
      end
    endcase
  end
endmodule

// >>> rtl/luexe_pkg.sv
// types of the upper-immediate, logical and branch execution unit
package luexe_pkg;
  typedef enum logic [7:0] {
    LUEXE_NONE = 8'h01,
    LUEXE_AND = 8'h02,
    LUEXE_MASK = 8'h04,
    LUEXE_ADD = 8'h08,
    LUEXE_PCADD = 8'h10,
    LUEXE_BRANCH = 8'h20,
    LUEXE_TRAP = 8'h40,
    LUEXE_LINK = 8'h80
  } luexe_kind_t;
endpackage

// >>> rtl/luexe_regs.svh
// constants of the upper-immediate, logical and branch execution unit
`ifndef LUEXE_REGS_SVH
`define LUEXE_REGS_SVH
`define LUEXE_OP_SPECIAL 6'h00
`define LUEXE_OP_REGIMM 6'h01
`define LUEXE_OP_EQ_BRANCH 6'h04
`define LUEXE_OP_MASK_CONST 6'h0C
`define LUEXE_OP_UPPER_ADD 6'h0F
`define LUEXE_OP_DWORD_UPPER 6'h1D
`define LUEXE_OP_PCREL 6'h3B
`define LUEXE_FN_AND 6'h24
`define LUEXE_RT_HIGH_SLICE 5'h06
`define LUEXE_RT_TOP_SLICE 5'h1E
`define LUEXE_RT_LINK_BRANCH 5'h11
`define LUEXE_RT_PC_UPPER 5'h1E
`define LUEXE_RT_PC_UPPER_AL 5'h1F
`define LUEXE_LINK_REG 5'h1F
`define LUEXE_UPPER_SHIFT 16
`define LUEXE_HIGH_SHIFT 32
`define LUEXE_TOP_SHIFT 48
`define LUEXE_BR_SHIFT 2
`define LUEXE_LINK_STEP 64'h0000000000000008
`define LUEXE_SLOT_STEP 64'h0000000000000004
`endif

// >>> verif/luexe_core_bench.sv
// self-checking bench for the execution unit
module luexe_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, en64, issue, wr_en_q, redirect_q, trap_q;
  logic [31:0] instr;
  logic [63:0] pc, src_a, src_b, wr_data_q, target_q;
  logic [4:0] wr_reg_q;
  int error_cnt = 0;
  int checked = 0;
  luexe_pipe_model pipe_u (.clk(clk), .issue(issue), .instr(instr), .pc(pc), .src_a(src_a), .src_b(src_b));
  luexe_core dut_u (.clk(clk), .rstn(rstn), .issue(issue), .instr(instr), .pc(pc), .src_a(src_a),
    .src_b(src_b), .en64(en64), .wr_en_q(wr_en_q), .wr_reg_q(wr_reg_q), .wr_data_q(wr_data_q),
    .redirect_q(redirect_q), .target_q(target_q), .trap_q(trap_q));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string n, input logic [63:0] e, g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // one word issued, its pulse judged in the cycle after it stands
  task automatic run(input logic [31:0] i, input logic [63:0] p, a, b, input logic [4:0] r,
    input logic [63:0] e, input logic w, t);
    pipe_u.send(i, p, a, b);
    chk("wr_en", {63'h0, w}, {63'h0, wr_en_q});
    chk("trap", {63'h0, t}, {63'h0, trap_q});
    if (w) begin
      chk("wr_reg", {59'h0, r}, {59'h0, wr_reg_q});
      chk("wr_data", e, wr_data_q);
    end
  endtask
  task automatic do_reset();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (12) @(posedge clk);
    chk("reset", 64'h0, {61'h0, wr_en_q, trap_q, redirect_q});
    chk("reset target", 64'h0, target_q);
    rstn <= 1'b1;
  endtask
  task automatic t_logic();
    run(32'h0022_1824, 64'h0, 64'hF0F0_1234_FFFF_0000, 64'h0FF0_FFFF_00FF_FF00, 5'h03,
      64'h00F0_1234_00FF_0000, 1'h1, 1'h0);
    run(32'h3024_8001, 64'h0, '1, 64'h0, 5'h04, 64'h8001, 1'h1, 1'h0);
    $display("logic end");
  endtask
  task automatic t_upper();
    run(32'h3C25_0001, 64'h0, 64'h1_7FFF_0000, 64'h0, 5'h05, 64'hFFFF_FFFF_8000_0000, 1'h1, 1'h0);
    run(32'h7426_FFFF, 64'h0, 64'h1_0000_0000, 64'h0, 5'h06, 64'hFFFF_0000, 1'h1, 1'h0);
    run(32'h04E6_8000, 64'h0, 64'h0, 64'h0, 5'h07, 64'hFFFF_8000_0000_0000, 1'h1, 1'h0);
    run(32'h051E_1234, 64'h0, 64'h1, 64'h0, 5'h08, 64'h1234_0000_0000_0001, 1'h1, 1'h0);
    run(32'hED3E_0001, 64'h7FFF_1234, 64'h0, 64'h0, 5'h09, 64'hFFFF_FFFF_8000_1234, 1'h1, 1'h0);
    run(32'hED5F_0002, 64'h1000_ABCD, 64'h0, 64'h0, 5'h0A, 64'h1002_0000, 1'h1, 1'h0);
    $display("upper end");
  endtask
  task automatic t_trap();
    run(32'h7406_0001, 64'h0, 64'h5, 64'h0, 5'h00, 64'h0, 1'h0, 1'h1);
    @(posedge clk);
    en64 <= 1'b0;
    run(32'h04E6_0001, 64'h0, 64'h5, 64'h0, 5'h00, 64'h0, 1'h0, 1'h1);
    run(32'h3C05_0001, 64'h0, 64'h0, 64'h0, 5'h05, 64'h1_0000, 1'h1, 1'h0);
    @(posedge clk);
    en64 <= 1'b1;
    $display("trap end");
  endtask
  task automatic t_branch();
    run(32'h1000_FFFE, 64'h1000, 64'h0, 64'h0, 5'h00, 64'h0, 1'h0, 1'h0);
    chk("early", 64'h0, {63'h0, redirect_q});
    run(32'h0022_1824, 64'h1004, 64'h3, 64'h6, 5'h03, 64'h2, 1'h1, 1'h0);
    chk("redirect", 64'h1, {63'h0, redirect_q});
    chk("target", 64'hFFC, target_q);
    run(32'h0411_0004, 64'h2000, 64'h0, 64'h0, 5'h1F, 64'h2008, 1'h1, 1'h0);
    // a branch placed in the slot on purpose, which software must not do
    run(32'h1000_0001, 64'h2004, 64'h0, 64'h0, 5'h00, 64'h0, 1'h0, 1'h1);
    chk("redirect", 64'h1, {63'h0, redirect_q});
    chk("target", 64'h2014, target_q);
    // equal compare on live registers only opens a slot in this unit
    run(32'h1022_0003, 64'h4000, 64'h1, 64'h2, 5'h00, 64'h0, 1'h0, 1'h0);
    run(32'h0022_1824, 64'h4004, 64'h3, 64'h6, 5'h03, 64'h2, 1'h1, 1'h0);
    chk("no redirect", 64'h0, {63'h0, redirect_q});
    // reset while a slot is open must forget the pending branch
    run(32'h1000_0004, 64'h3000, 64'h0, 64'h0, 5'h00, 64'h0, 1'h0, 1'h0);
    do_reset();
    run(32'h0022_1824, 64'h3004, 64'h3, 64'h6, 5'h03, 64'h2, 1'h1, 1'h0);
    chk("stale redirect", 64'h0, {63'h0, redirect_q});
    $display("branch end");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    en64 = 1'b1;
    do_reset();
    t_logic();
    t_upper();
    t_trap();
    t_branch();
    end_sim();
  end
  // hang guard
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule

// >>> verif/luexe_core_sva.sv
// port assertions for the execution unit
module luexe_core_sva (
  input wire logic clk,
  input wire logic rstn,
  input wire logic issue,
  input wire logic [31:0] instr,
  input wire logic [63:0] pc,
  input wire logic [63:0] src_a,
  input wire logic [63:0] src_b,
  input wire logic en64,
  input wire logic wr_en_q,
  input wire logic [4:0] wr_reg_q,
  input wire logic [63:0] wr_data_q,
  input wire logic redirect_q,
  input wire logic trap_q,
  input wire logic [63:0] target_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // decoded views of the issued word
  wire [5:0] op = instr[31:26];
  wire [31:0] s32 = src_a[31:0] + {instr[15:0], 16'h0000};
  wire [63:0] imm16 = {{32{instr[15]}}, instr[15:0], 16'h0000};
  a_trap_no_write: assert property (trap_q |-> !wr_en_q) else $error("write beside trap");
  a_and_result: assert property (issue && op == 6'h00 && instr[10:0] == 11'h024 |=>
    wr_en_q && wr_data_q == $past(src_a & src_b)) else $error("and result");
  a_mask_zero_ext: assert property (issue && op == 6'h0C |=> wr_reg_q == $past(instr[20:16])
    && wr_data_q == $past(src_a & {48'h0, instr[15:0]})) else $error("mask result");
  a_upper_sext: assert property (issue && op == 6'h0F |=>
    wr_data_q == {{32{$past(s32[31])}}, $past(s32)}) else $error("upper add");
  a_dword_sum: assert property (issue && op == 6'h1D && en64 && instr[25:21] != 5'h00 |=>
    wr_data_q == $past(src_a + imm16)) else $error("dword add");
  a_dword_zero_trap: assert property (issue && op == 6'h1D && instr[25:21] == 5'h00 |=>
    trap_q) else $error("dword zero source");
  a_disabled_trap: assert property (issue && op == 6'h01 && !en64 && instr[20:16] == 5'h06 |=>
    trap_q) else $error("64-bit disabled");
  a_link_value: assert property (issue && op == 6'h01 && instr[25:16] == 10'h011 |=>
    wr_reg_q == 5'h1F && wr_data_q == $past(pc) + 64'h8) else $error("link value");
  a_redirect_after: assert property (redirect_q |-> $past(issue)) else $error("redirect cause");
  a_target_steady: assert property (!redirect_q |-> target_q == $past(target_q)) else $error("target moved");
  // main scenarios reached
  c_trap: cover property (trap_q);
  c_redirect: cover property (redirect_q && wr_en_q);
  c_link: cover property (wr_en_q && wr_reg_q == 5'h1F);
endmodule
bind luexe_core luexe_core_sva chk_u (.*);

// >>> verif/luexe_pipe_model.sv
// pipeline model issuing one instruction at a time
module luexe_pipe_model (
  input wire logic clk,
  output logic issue,
  output logic [31:0] instr,
  output logic [63:0] pc,
  output logic [63:0] src_a,
  output logic [63:0] src_b
);
  // quiet, known bus until the first word is sent
  initial begin
    issue = 1'b0;
    {instr, pc, src_a, src_b} = '0;
  end
  // released operands are scrambled so stale values never match by luck
  task automatic send(input logic [31:0] i, input logic [63:0] p, a, b);
    @(posedge clk);
    issue <= 1'b1;
    {instr, pc, src_a, src_b} <= {i, p, a, b};
    @(posedge clk);
    issue <= 1'b0;
    {instr, pc, src_a, src_b} <= ~{i, p, a, b};
    #1;
  endtask
endmodule
